// *** logic/sync_init_pkg.sv ***
package sync_init_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG_A = 8'h00;
  localparam logic [7:0] OFS_ADDR_MAP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PIN_STATE = 8'h0C;

  // config_a_a field layout
  localparam int SW_TX_LSB = 0;
  localparam int BUS_IF_LSB = 4;
  localparam int SYNC_W = 4;
  localparam int MAP_W = 9;

  // reset values: 3 clock delays, positive edge (about 75 ns at 25 ns)
  localparam logic [3:0] SYNC_SETTING_RST = 4'h4;
  localparam logic [8:0] ADDR_MAP_RST = 9'h000;

  // highest legal setting code
  localparam logic [3:0] SYNC_CODE_MAX = 4'h9;
  localparam int VAR_TAPS = 5;

  // fixed-delay synchronizer settling time and derived stage count
  localparam int CLK_PERIOD_PS = 25000;
  localparam int FIXED_SETTLE_PS = 100000;
  localparam int FIXED_STAGES = (FIXED_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // status bit positions
  localparam int ST_QUIESCENT = 0;
  localparam int ST_MAPPED = 1;
  localparam int ST_OPERATIONAL = 2;
  localparam int ST_BAD_SETTING = 3;
  localparam int ST_EXEC_DONE = 4;

  typedef enum logic [3:0] {
    INIT_RESET = 4'b0001,
    INIT_QUIESCENT = 4'b0010,
    INIT_MAPPED = 4'b0100,
    INIT_OPERATIONAL = 4'b1000
  } init_state_e;

  typedef struct packed {
    logic [3:0] bus_iface_sync_setting;
    logic [3:0] switch_tx_sync_setting;
  } config_a_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // tap index 0..4 for a setting, codes above the max clamp to the last tap
  function automatic logic [2:0] sync_tap(input logic [3:0] code);
    sync_tap = (code > SYNC_CODE_MAX) ? 3'(VAR_TAPS - 1) : code[3:1];
  endfunction

  function automatic logic sync_code_bad(input logic [3:0] code);
    sync_code_bad = code > SYNC_CODE_MAX;
  endfunction

endpackage

// *** logic/fixed_delay_sync.sv ***
`timescale 1ns/100ps
module fixed_delay_sync #(
  parameter int STAGES = 4,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // level in and out
  input wire logic din,
  output logic dout
);

  logic [STAGES-1:0] chain_ff;

  // plain shift chain, only the last stage is read
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chain_ff <= {STAGES{RST_VAL}};
    end
    else if (clk_en)
    begin
      chain_ff <= {chain_ff[STAGES-2:0], din};
    end
  end

  assign dout = chain_ff[STAGES-1];

endmodule

// *** logic/var_delay_sync.sv ***
`timescale 1ns/100ps
module var_delay_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // delay and edge setting
  input wire logic [3:0] setting,
  // level in and out
  input wire logic din,
  output logic dout
);
  import sync_init_pkg::*;

  logic cap_pos_ff;
  logic cap_neg_ff;
  logic pos_s2_ff;
  logic neg_s2_ff;
  logic [VAR_TAPS-1:0] tap_ff;
  logic dout_ff;

  // capture on the rising edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_pos_ff <= 1'b0;
      pos_s2_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      cap_pos_ff <= din;
      pos_s2_ff <= cap_pos_ff;
    end
  end

  // capture on the falling edge
  always_ff @(negedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_neg_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      cap_neg_ff <= din;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      neg_s2_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      neg_s2_ff <= cap_neg_ff;
    end
  end

  // fixed-length tap chain gives a constant delay for every input change
  // edge select
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tap_ff <= '0;
    end
    else if (clk_en)
    begin
      tap_ff <= {tap_ff[VAR_TAPS-2:0], setting[0] ? neg_s2_ff : pos_s2_ff};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      dout_ff <= tap_ff[sync_tap(setting)];
    end
  end

  assign dout = dout_ff;

endmodule

// *** logic/multi_clock_sync_and_init.sv ***
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
// Function
// - external reset reaches internal logic through a fixed-delay synchronizer.
// - execute handshake release reaches bus access logic via fixed-delay synchronizer.
// - fixed-delay synchronizers settle at least 100 ns.
// - request and response crossings use variable-delay zero-uncertainty synchronizers.
// - every variable-delay synchronizer has its own 4-bit setting.
// - codes 0..9: bits 3..1 plus one is delay, bit 0 picks edge.
// - delay counts periods of the receiving clock.
// - switch-transmit and bus-interface settings are separate fields of config_a_a.
// - low external reset means hardware reset, high means normal operation.
// - after map and registers are initialized the device is operational.
// - reset is resynchronized everywhere, quiescent state entered on release.
module multi_clock_sync_and_init (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // external pins
  input wire logic ext_reset_n,
  input wire logic ctl_exec_handshake_n,
  // function request and response levels
  input wire logic switch_tx_req_in,
  output logic switch_tx_req_out,
  input wire logic bus_iface_resp_in,
  output logic bus_iface_resp_out,
  // register port
  input wire sync_init_pkg::reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  // state outputs
  output logic quiescent,
  output logic operational,
  output logic bus_access_en
);
  import sync_init_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  logic rst_meta_ff;
  logic rst_n;
  logic hw_reset_n;
  logic exec_n_sync;
  logic exec_n_d_ff;
  config_a_s config_a_a_ff;
  logic [MAP_W-1:0] config_unit_addr_map_ff;
  logic bad_setting_ff;
  logic exec_done_ff;
  logic [31:0] rdata_ff;
  init_state_e state_ff;
  init_state_e nxt_state;
  logic sw_tx_raw;
  logic bus_if_raw;
  logic wr_cfg;
  logic wr_map;
  logic wr_status;
  logic set_bad;

  ////////////////////////////////////////////////////////////////////////////
  // core reset release through two flops

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed-delay synchronizers

  fixed_delay_sync #(
    .STAGES(FIXED_STAGES),
    .RST_VAL(1'b0)
  ) u_ext_reset_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(ext_reset_n),
    .dout(hw_reset_n)
  );

  fixed_delay_sync #(
    .STAGES(FIXED_STAGES),
    .RST_VAL(1'b1)
  ) u_exec_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(ctl_exec_handshake_n),
    .dout(exec_n_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // variable-delay synchronizers on the function paths

  var_delay_sync u_sw_tx_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .setting(config_a_a_ff.switch_tx_sync_setting),
    .din(switch_tx_req_in),
    .dout(sw_tx_raw)
  );

  var_delay_sync u_bus_if_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .setting(config_a_a_ff.bus_iface_sync_setting),
    .din(bus_iface_resp_in),
    .dout(bus_if_raw)
  );

  // paths stay disabled until operational
  assign switch_tx_req_out = sw_tx_raw & operational;
  assign bus_iface_resp_out = bus_if_raw & operational;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  assign wr_cfg = reg_req.wr && reg_req.addr == OFS_CONFIG_A;
  assign wr_map = reg_req.wr && reg_req.addr == OFS_ADDR_MAP;
  assign wr_status = reg_req.wr && reg_req.addr == OFS_STATUS;

  assign set_bad = wr_cfg && (sync_code_bad(reg_req.wdata[SW_TX_LSB +: SYNC_W])
                   || sync_code_bad(reg_req.wdata[BUS_IF_LSB +: SYNC_W]));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_a_a_ff <= '{SYNC_SETTING_RST, SYNC_SETTING_RST};
    end
    else if (clk_en)
    begin
      if (!hw_reset_n)
      begin
        config_a_a_ff <= '{SYNC_SETTING_RST, SYNC_SETTING_RST};
      end
      else if (wr_cfg && !state_ff[1])
      begin
        config_a_a_ff.switch_tx_sync_setting <= reg_req.wdata[SW_TX_LSB +: SYNC_W];
        config_a_a_ff.bus_iface_sync_setting <= reg_req.wdata[BUS_IF_LSB +: SYNC_W];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_unit_addr_map_ff <= ADDR_MAP_RST;
    end
    else if (clk_en)
    begin
      if (!hw_reset_n)
      begin
        config_unit_addr_map_ff <= ADDR_MAP_RST;
      end
      else if (wr_map)
      begin
        config_unit_addr_map_ff <= reg_req.wdata[MAP_W-1:0];
      end
    end
  end

  // sticky bad-setting flag, set wins over write-one clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_setting_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!hw_reset_n)
      begin
        bad_setting_ff <= 1'b0;
      end
      else if (set_bad)
      begin
        bad_setting_ff <= 1'b1;
      end
      else if (wr_status && reg_req.wdata[ST_BAD_SETTING])
      begin
        bad_setting_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execute handshake release opens bus access

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exec_n_d_ff <= 1'b1;
      exec_done_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      exec_n_d_ff <= exec_n_sync;
      if (!hw_reset_n)
      begin
        exec_done_ff <= 1'b0;
      end
      else if (exec_n_sync && !exec_n_d_ff)
      begin
        exec_done_ff <= 1'b1;
      end
      else if (!exec_n_sync)
      begin
        exec_done_ff <= 1'b0;
      end
    end
  end

  assign bus_access_en = exec_done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // initialization state machine

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      INIT_RESET:
      begin
        if (hw_reset_n)
        begin
          nxt_state = INIT_QUIESCENT;
        end
      end
      INIT_QUIESCENT:
      begin
        if (wr_map)
        begin
          nxt_state = INIT_MAPPED;
        end
      end
      INIT_MAPPED:
      begin
        if (wr_cfg)
        begin
          nxt_state = INIT_OPERATIONAL;
        end
      end
      INIT_OPERATIONAL:
      begin
        nxt_state = INIT_OPERATIONAL;
      end
      default:
      begin
        nxt_state = INIT_RESET;
      end
    endcase
    if (!hw_reset_n)
    begin
      nxt_state = INIT_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= INIT_RESET;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
    end
  end

  assign quiescent = state_ff == INIT_QUIESCENT;
  assign operational = state_ff == INIT_OPERATIONAL;

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          OFS_CONFIG_A:
          begin
            rdata_ff <= {24'h00_0000, config_a_a_ff};
          end
          OFS_ADDR_MAP:
          begin
            rdata_ff <= {23'h00_0000, config_unit_addr_map_ff};
          end
          OFS_STATUS:
          begin
            rdata_ff <= {27'h000_0000, exec_done_ff, bad_setting_ff,
                         state_ff == INIT_OPERATIONAL, state_ff == INIT_MAPPED,
                         state_ff == INIT_QUIESCENT};
          end
          OFS_PIN_STATE:
          begin
            rdata_ff <= {28'h000_0000, bus_if_raw, sw_tx_raw, exec_n_sync, hw_reset_n};
          end
          default:
          begin
            rdata_ff <= 32'h0000_0000;
          end
        endcase
      end
      else
      begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

// *** testbench/tcu_model.sv ***
`timescale 1ns/100ps
module tcu_model (
  // clock
  input wire logic core_clk,
  // command from the bench, high while executing
  input wire logic exec_req,
  // execute handshake pin, low while executing
  output logic ctl_exec_handshake_n
);
  // pin changes only just after a rising edge
  always @(posedge core_clk)
  begin
    ctl_exec_handshake_n <= !exec_req;
  end
endmodule

// *** testbench/sync_init_asserts.sv ***
`timescale 1ns/100ps
module sync_init_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // pins and paths
  input wire logic ext_reset_n,
  input wire logic ctl_exec_handshake_n,
  input wire logic switch_tx_req_in,
  input wire logic switch_tx_req_out,
  input wire logic bus_iface_resp_in,
  input wire logic bus_iface_resp_out,
  // register port and state
  input wire sync_init_pkg::reg_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic quiescent,
  input wire logic operational,
  input wire logic bus_access_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence ext_held;
    (!ext_reset_n && clk_en)[*6];
  endsequence
  sequence ext_gone;
    $rose(ext_reset_n) ##0 (ext_reset_n && clk_en)[*8];
  endsequence
  //////////////////////////////////////////
  rdata_idle_a: assert property ($past(clk_en) && !$past(reg_req.rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  gate_off_a: assert property (!operational |-> !switch_tx_req_out && !bus_iface_resp_out)
    else $error("path output while not operational");
  one_state_a: assert property (!(quiescent && operational))
    else $error("quiescent and operational together");
  rst_takes_a: assert property (ext_held |=> !quiescent && !operational)
    else $error("external reset not taken");
  rst_settle_a: assert property (operational && $fell(ext_reset_n) |-> operational[*3])
    else $error("reset synchronizer too fast");
  rst_release_a: assert property (ext_gone |-> quiescent)
    else $error("no quiescent state after reset");
  exec_min_a: assert property ($rose(bus_access_en) |-> $past(ctl_exec_handshake_n, 4))
    else $error("handshake synchronizer too fast");
  exec_on_a: assert property ($rose(ctl_exec_handshake_n) ##1
    (ctl_exec_handshake_n && operational)[*7] |-> bus_access_en)
    else $error("bus access not enabled");
  exec_off_a: assert property ($fell(ctl_exec_handshake_n) ##1
    (!ctl_exec_handshake_n)[*7] |-> !bus_access_en)
    else $error("bus access not withdrawn");
  sw_min_a: assert property ($rose(switch_tx_req_out) |-> $past(switch_tx_req_in, 2))
    else $error("switch path too fast");
  bi_min_a: assert property ($rose(bus_iface_resp_out) |-> $past(bus_iface_resp_in, 2))
    else $error("bus path too fast");
endmodule
bind multi_clock_sync_and_init sync_init_asserts sync_init_asserts_i (.core_clk(core_clk),
  .nrst(nrst), .clk_en(clk_en), .ext_reset_n(ext_reset_n),
  .ctl_exec_handshake_n(ctl_exec_handshake_n), .switch_tx_req_in(switch_tx_req_in),
  .switch_tx_req_out(switch_tx_req_out), .bus_iface_resp_in(bus_iface_resp_in),
  .bus_iface_resp_out(bus_iface_resp_out), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .quiescent(quiescent), .operational(operational), .bus_access_en(bus_access_en));

// *** testbench/test_multi_clock_sync_and_init.sv ***
`timescale 1ns/100ps
module test_multi_clock_sync_and_init;
  import sync_init_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic ext_reset_n = 1'b1;
  logic exec_req = 1'b1;
  logic hs_n;
  logic sw_in = 1'b0;
  logic bi_in = 1'b0;
  logic sw_out, bi_out, quiescent, operational, bus_access_en;
  reg_req_s reg_req = '0;
  logic [31:0] reg_rdata;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  multi_clock_sync_and_init multi_clock_sync_and_init_i (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .ext_reset_n(ext_reset_n), .ctl_exec_handshake_n(hs_n),
    .switch_tx_req_in(sw_in), .switch_tx_req_out(sw_out), .bus_iface_resp_in(bi_in),
    .bus_iface_resp_out(bi_out), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .quiescent(quiescent), .operational(operational), .bus_access_en(bus_access_en));
  tcu_model tcu_model_i (.core_clk(core_clk), .exec_req(exec_req), .ctl_exec_handshake_n(hs_n));
  initial forever #12.5 core_clk = ~core_clk;
  //////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    @(negedge core_clk);
    cmp(what, exp, reg_rdata);
    @(posedge core_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////
  task automatic t_init();
    repeat (10) @(posedge core_clk);
    rd(OFS_STATUS, 32'h0000_0001, "status quiet");
    rd(OFS_CONFIG_A, 32'h0000_0044, "config reset");
    rd(8'h10, 32'h0000_0000, "unmapped");
    // settings refused before the map is loaded
    wr(OFS_CONFIG_A, 32'h0000_0011);
    rd(OFS_CONFIG_A, 32'h0000_0044, "config early");
    // map first, then the other registers
    wr(OFS_ADDR_MAP, 32'h0000_03a5);
    rd(OFS_ADDR_MAP, 32'h0000_01a5, "map");
    rd(OFS_STATUS, 32'h0000_0002, "status mapped");
    wr(OFS_CONFIG_A, 32'h0000_0066);
    rd(OFS_CONFIG_A, 32'h0000_0066, "config set");
    rd(OFS_STATUS, 32'h0000_0004, "status up");
    $display("test init done");
  endtask
  task automatic t_paths();
    int n_sw;
    int n_bi;
    logic [3:0] cs;
    logic [3:0] cb;
    // legal codes only
    for (int i = 0; i < 10; i++)
    begin
      cb = 4'(i);
      cs = 4'(9 - i);
      wr(OFS_CONFIG_A, {24'h00_0000, cb, cs});
      sw_in <= 1'b1;
      bi_in <= 1'b1;
      n_sw = -1;
      n_bi = -1;
      for (int k = 0; k < 12; k++)
      begin
        @(negedge core_clk);
        if (sw_out === 1'b1 && n_sw < 0)
          n_sw = k;
        if (bi_out === 1'b1 && n_bi < 0)
          n_bi = k;
      end
      cmp("switch delay", 32'(int'(cs[3:1]) + 4 - int'(cs[0])), 32'(n_sw));
      cmp("bus delay", 32'(int'(cb[3:1]) + 4 - int'(cb[0])), 32'(n_bi));
      @(posedge core_clk);
      sw_in <= 1'b0;
      bi_in <= 1'b0;
      repeat (12) @(posedge core_clk);
    end
    $display("test paths done");
  endtask
  task automatic t_exec();
    int n;
    n = -1;
    exec_req <= 1'b0;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge core_clk);
      if (bus_access_en === 1'b1 && n < 0)
        n = k;
    end
    cmp("exec settle", 32'h0000_0001, 32'(n >= 5 && n <= 7));
    @(posedge core_clk);
    rd(OFS_STATUS, 32'h0000_0014, "status exec");
    rd(OFS_PIN_STATE, 32'h0000_0003, "pin state");
    exec_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    cmp("exec off", 32'h0000_0000, 32'(bus_access_en));
    @(posedge core_clk);
    $display("test exec done");
  endtask
  task automatic t_freeze();
    // a reset pulse while frozen must not be taken
    clk_en <= 1'b0;
    ext_reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    ext_reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    cmp("freeze", 32'h0000_0001, 32'(operational));
    @(posedge core_clk);
    $display("test freeze done");
  endtask
  task automatic t_extrst();
    ext_reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    cmp("reset settle", 32'h0000_0001, 32'(operational));
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    cmp("reset state", 32'h0000_0000, {30'h0, quiescent, operational});
    @(posedge core_clk);
    ext_reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    cmp("quiescent", 32'h0000_0001, 32'(quiescent));
    @(posedge core_clk);
    rd(OFS_CONFIG_A, 32'h0000_0044, "config after reset");
    $display("test ext reset done");
  endtask
  //////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_init();
    t_paths();
    t_exec();
    t_freeze();
    t_extrst();
    conclude();
  end
endmodule
